/* design/ppmc_core.sv */
/*
  Processor privilege mode control: pending-event vector, mode, protection and returns.
  Assumes event requests, instruction decode and return registers come from core-clock logic;
  only the external emulation event pin is asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none

module ppmc_core
  import ppmc_pkg::*;
(
  input  wire logic                 CLK_IN,
  input  wire logic                 RST_IN,
  input  wire logic                 CE_IN,
  input  wire logic                 EMU_RESET_IN,
  input  wire logic                 EMU_ENABLE_IN,
  input  wire logic                 EMU_EVENT_IN,
  input  wire logic                 EVT_REQ_IN,
  input  wire logic [3:0]           EVT_LEVEL_IN,
  input  wire logic                 INT_RET_SAVED_IN,
  input  wire logic                 PROT_DENY_IN,
  input  wire ppmc_pkg::ppmc_req_t  REQ_IN,
  input  wire ppmc_pkg::ppmc_ret_t  RET_IN,
  output logic [15:0]               PENDING_EVENT_VECTOR_OUT,
  output ppmc_pkg::ppmc_mode_t      MODE_OUT,
  output logic                      GRANT_OUT,
  output logic                      EXCEPTION_OUT,
  output logic                      RESUME_VALID_OUT,
  output logic [31:0]               RESUME_ADDR_OUT,
  output logic                      KERNEL_SP_OUT,
  output logic                      INT_ENABLE_OUT
);

  logic [15:0] vec_r;
  logic [15:0] vec_nxt;
  logic        rst_seen_r;
  logic        nest_ok_r;
  logic        int_en_r;
  logic        emu_meta_r;
  logic        emu_sync_r;
  logic        emu_prev_r;
  logic        grant_r;
  logic        exc_r;
  logic        resume_r;
  logic [31:0] addr_r;
  logic        ksp_r;
  ppmc_mode_t  mode_r;
  ppmc_mode_t  mode;
  logic        violation;
  logic        req_any;
  logic [15:0] clear_mask;
  logic        ret_resume;
  logic [31:0] ret_addr;
  logic [15:0] set_mask;
  logic [4:0]  active_lvl;
  logic        emu_edge;

  // Checks an incoming event level against what is in service now.
  function automatic logic ppmc_may_enter(input logic [3:0] lvl,
                                          input logic [4:0] act,
                                          input logic       rst_busy,
                                          input logic       nest_ok);
    logic ok;
    ok = ({1'b0, lvl} < act);
    if (rst_busy && lvl != 4'(BIT_EMU))
      ok = 1'b0;
    if (lvl >= 4'(BIT_INT_FIRST) && act >= 5'(BIT_INT_FIRST) && act < 5'(LVL_NONE) && !nest_ok)
      ok = 1'b0;
    return ok;
  endfunction : ppmc_may_enter

  assign mode       = ppmc_mode_of(vec_r);
  assign active_lvl = ppmc_active_level(vec_r);
  assign req_any    = REQ_IN.mem_valid || REQ_IN.reg_valid || (REQ_IN.op != OP_NONE);
  assign emu_edge   = emu_sync_r && !emu_prev_r;

  ppmc_access_guard u_ppmc_access_guard (
    .mode_in       (mode),
    .req_in        (REQ_IN),
    .prot_deny_in  (PROT_DENY_IN),
    .violation_out (violation)
  );

  ppmc_return_unit u_ppmc_return_unit (
    .op_in          (REQ_IN.op),
    .vec_in         (vec_r),
    .ret_in         (RET_IN),
    .clear_mask_out (clear_mask),
    .resume_out     (ret_resume),
    .addr_out       (ret_addr)
  );

  // The pin is asynchronous; the second stage and its delayed third-stage copy feed the edge detector.
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      emu_meta_r <= 1'b0;
      emu_sync_r <= 1'b0;
      emu_prev_r <= 1'b0;
    end
    else if (CE_IN)
    begin
      emu_meta_r <= EMU_EVENT_IN;
      emu_sync_r <= emu_meta_r;
      emu_prev_r <= emu_sync_r;
    end
  end

  always_comb
  begin
    set_mask = VEC_CLEAR;
    if (EMU_ENABLE_IN && (emu_edge || (REQ_IN.op == OP_EMU_EXCEPTION && !violation)))
      set_mask[BIT_EMU] = 1'b1;
    if (req_any && violation && ppmc_may_enter(4'(BIT_EXC), active_lvl, vec_r[BIT_RST],
        nest_ok_r))
      set_mask[BIT_EXC] = 1'b1;
    if (EVT_REQ_IN && ppmc_may_enter(EVT_LEVEL_IN, active_lvl, vec_r[BIT_RST], nest_ok_r)
        && (EVT_LEVEL_IN < 4'(BIT_GLOBAL_EN) || int_en_r))
      set_mask[EVT_LEVEL_IN] = 1'b1;
    if (REQ_IN.op == OP_RAISE && !violation
        && ppmc_may_enter(REQ_IN.raise_level, active_lvl, vec_r[BIT_RST], nest_ok_r))
      set_mask[REQ_IN.raise_level] = 1'b1;
    vec_nxt = vec_r;
    if (!violation && ret_resume)
      vec_nxt = vec_nxt & ~clear_mask;
    vec_nxt = vec_nxt | set_mask;
  end

  // A plain reset leaves supervisor servicing reset; an emulator reset adds emulation.
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      vec_r      <= VEC_CLEAR;
      rst_seen_r <= 1'b1;
    end
    else if (CE_IN)
    begin
      rst_seen_r <= 1'b0;
      if (rst_seen_r)
        vec_r <= EMU_RESET_IN ? VEC_EMU_RESET : VEC_RESET_OUT;
      else
        vec_r <= vec_nxt;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      nest_ok_r <= 1'b0;
    else if (CE_IN)
    begin
      if (INT_RET_SAVED_IN)
        nest_ok_r <= 1'b1;
      else if (|set_mask[15:BIT_INT_FIRST] || (REQ_IN.op == OP_RET_INT && !violation))
        nest_ok_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      int_en_r <= 1'b0;
    else if (CE_IN && !violation)
    begin
      if (REQ_IN.op == OP_INT_DISABLE)
        int_en_r <= 1'b0;
      else if (REQ_IN.op == OP_INT_ENABLE)
        int_en_r <= 1'b1;
    end
  end

  // Grant is withheld for any violation so no state changes before the exception.
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      grant_r  <= 1'b0;
      exc_r    <= 1'b0;
      resume_r <= 1'b0;
      addr_r   <= ADDR_CLEAR;
    end
    else if (CE_IN)
    begin
      grant_r  <= req_any && !violation && !rst_seen_r;
      exc_r    <= req_any && violation && !rst_seen_r;
      resume_r <= ret_resume && !violation && !rst_seen_r;
      if (ret_resume && !violation)
        addr_r <= ret_addr;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      mode_r <= PPMC_USER;
      ksp_r  <= 1'b0;
    end
    else if (CE_IN)
    begin
      if (rst_seen_r)
      begin
        mode_r <= ppmc_mode_of(EMU_RESET_IN ? VEC_EMU_RESET : VEC_RESET_OUT);
        ksp_r  <= 1'b1;
      end
      else
      begin
        mode_r <= ppmc_mode_of(vec_nxt);
        ksp_r  <= (ppmc_mode_of(vec_nxt) != PPMC_USER);
      end
    end
  end

  assign PENDING_EVENT_VECTOR_OUT = vec_r;
  assign MODE_OUT                 = mode_r;
  assign GRANT_OUT                = grant_r;
  assign EXCEPTION_OUT            = exc_r;
  assign RESUME_VALID_OUT         = resume_r;
  assign RESUME_ADDR_OUT          = addr_r;
  assign KERNEL_SP_OUT            = ksp_r;
  assign INT_ENABLE_OUT           = int_en_r;

  property p_emu_bit;
    @(posedge CLK_IN) disable iff (RST_IN)
      vec_r[BIT_EMU] |-> mode_r == PPMC_EMU;
  endproperty
  a_emu_bit: assert property (p_emu_bit) else $error("emulation bit without emulation mode");

  property p_idle_user;
    @(posedge CLK_IN) disable iff (RST_IN)
      (vec_r == VEC_CLEAR) |-> (mode_r == PPMC_USER && !ksp_r);
  endproperty
  a_idle_user: assert property (p_idle_user) else $error("idle vector not user mode");

  property p_reset_exit;
    @(posedge CLK_IN)
      (RST_IN ##1 (!RST_IN && CE_IN && !EMU_RESET_IN)) |=>
        (vec_r == VEC_RESET_OUT && mode_r == PPMC_SUPER);
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("reset exit vector wrong");

  property p_emu_reset;
    @(posedge CLK_IN)
      (RST_IN ##1 (!RST_IN && CE_IN && EMU_RESET_IN)) |=> mode_r == PPMC_EMU;
  endproperty
  a_emu_reset: assert property (p_emu_reset) else $error("emulator reset not in emulation");

  property p_user_mmr;
    @(posedge CLK_IN) disable iff (RST_IN)
      (CE_IN && !rst_seen_r && mode == PPMC_USER && REQ_IN.mem_valid
       && REQ_IN.mem_addr >= MMR_BASE) |=> (exc_r && !grant_r);
  endproperty
  a_user_mmr: assert property (p_user_mmr) else $error("user mmr access not trapped");

  property p_user_reg;
    @(posedge CLK_IN) disable iff (RST_IN)
      (CE_IN && !rst_seen_r && mode == PPMC_USER && REQ_IN.reg_valid && !REQ_IN.mem_valid
       && REQ_IN.op == OP_NONE)
        |=> (grant_r == ($past(REQ_IN.reg_class) < RC_USER_STACK_ALIAS));
  endproperty
  a_user_reg: assert property (p_user_reg) else $error("user register check wrong");

  property p_emu_ret_outside;
    @(posedge CLK_IN) disable iff (RST_IN)
      (CE_IN && !rst_seen_r && REQ_IN.op == OP_RET_EMU && mode != PPMC_EMU) |=>
        (exc_r && !resume_r);
  endproperty
  a_emu_ret_outside: assert property (p_emu_ret_outside) else $error("emulation return ran outside");

  property p_int_ret_addr;
    @(posedge CLK_IN) disable iff (RST_IN)
      (CE_IN && !rst_seen_r && REQ_IN.op == OP_RET_INT && mode == PPMC_SUPER && !PROT_DENY_IN)
        |=> (resume_r && addr_r == $past(RET_IN.int_ret));
  endproperty
  a_int_ret_addr: assert property (p_int_ret_addr) else $error("interrupt return address wrong");

  property p_reset_hold;
    @(posedge CLK_IN) disable iff (RST_IN)
      (CE_IN && !rst_seen_r && vec_r[BIT_RST] && EVT_REQ_IN && EVT_LEVEL_IN > 4'(BIT_RST))
        |=> !vec_r[$past(EVT_LEVEL_IN)];
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("event pre-empted reset");

  property p_lowest_stays;
    @(posedge CLK_IN) disable iff (RST_IN)
      (CE_IN && !rst_seen_r && vec_r[15] && REQ_IN.op != OP_RET_INT) |=> vec_r[15];
  endproperty
  a_lowest_stays: assert property (p_lowest_stays) else $error("lowest level dropped");

endmodule : ppmc_core

`default_nettype wire

/* include/ppmc_pkg.sv */
/*
  Shared constants, types and decode functions for the privilege mode control block.
  Assumes a single core clock domain and the pending-event bit order emu, reset, nmi, exc, ints.
*/
package ppmc_pkg;

  localparam int          VEC_W         = 16;
  localparam int          BIT_EMU       = 0;
  localparam int          BIT_RST       = 1;
  localparam int          BIT_NMI       = 2;
  localparam int          BIT_EXC       = 3;
  localparam int          BIT_INT_FIRST = 4;
  localparam int          BIT_GLOBAL_EN = 5;
  localparam int          LVL_NONE      = 16;
  localparam logic [15:0] VEC_CLEAR     = 16'h0000;
  localparam logic [15:0] VEC_RESET_OUT = 16'h0002;
  localparam logic [15:0] VEC_EMU_RESET = 16'h0003;
  localparam logic [31:0] MMR_BASE      = 32'hFFC0_0000;
  localparam logic [31:0] ADDR_CLEAR    = 32'h0000_0000;

  typedef enum logic [1:0] {PPMC_USER, PPMC_SUPER, PPMC_EMU} ppmc_mode_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_RET_INT, OP_RET_EXC, OP_RET_NMI, OP_RET_EMU,
    OP_INT_DISABLE, OP_INT_ENABLE, OP_RAISE, OP_EMU_EXCEPTION
  } ppmc_op_t;

  // Classes from RC_USER_STACK_ALIAS upward are closed to user mode.
  typedef enum logic [3:0] {
    RC_DATA, RC_ACCUM, RC_POINTER, RC_INDEX, RC_MODIFY, RC_LENGTH, RC_BASE,
    RC_SUBRET, RC_LOOP, RC_ARITH_STATUS, RC_CYCLES, RC_USER_STACK_ALIAS, RC_EVENT_RET,
    RC_SYSTEM
  } ppmc_regclass_t;

  typedef struct packed {
    logic           mem_valid;
    logic           mem_write;
    logic [31:0]    mem_addr;
    logic           reg_valid;
    ppmc_regclass_t reg_class;
    ppmc_op_t       op;
    logic [3:0]     raise_level;
  } ppmc_req_t;

  typedef struct packed {
    logic [31:0] int_ret;
    logic [31:0] exc_ret;
    logic [31:0] nmi_ret;
    logic [31:0] emu_ret;
  } ppmc_ret_t;

  function automatic ppmc_mode_t ppmc_mode_of(input logic [15:0] vec);
    if (vec[BIT_EMU])
      return PPMC_EMU;
    else if (vec != VEC_CLEAR)
      return PPMC_SUPER;
    else
      return PPMC_USER;
  endfunction : ppmc_mode_of

  // Index of the highest-priority event in service, LVL_NONE when idle.
  function automatic logic [4:0] ppmc_active_level(input logic [15:0] vec);
    logic [4:0] lvl;
    lvl = 5'(LVL_NONE);
    for (int i = VEC_W - 1; i >= 0; i--)
      if (vec[i])
        lvl = 5'(i);
    return lvl;
  endfunction : ppmc_active_level

endpackage : ppmc_pkg

/* design/ppmc_access_guard.sv */
/*
  Combinational protection check for one request: user-mode limits, emulation-only return and denied memory.
  Assumes the request is held stable by the issuing stage for the checking cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module ppmc_access_guard
  import ppmc_pkg::*;
(
  input  wire ppmc_pkg::ppmc_mode_t mode_in,
  input  wire ppmc_pkg::ppmc_req_t  req_in,
  input  wire logic                 prot_deny_in,
  output logic                      violation_out
);

  logic user_mode;
  logic mmr_hit;
  logic reg_bad;
  logic op_bad;

  always_comb
  begin
    user_mode = (mode_in == PPMC_USER);
    mmr_hit   = req_in.mem_valid && (req_in.mem_addr >= MMR_BASE);
    reg_bad   = req_in.reg_valid && (req_in.reg_class >= RC_USER_STACK_ALIAS);
    case (req_in.op)
      OP_RET_INT, OP_RET_EXC, OP_RET_NMI, OP_INT_DISABLE, OP_INT_ENABLE, OP_RAISE:
        op_bad = user_mode;
      OP_RET_EMU:
        op_bad = (mode_in != PPMC_EMU);
      default:
        op_bad = 1'b0;
    endcase
    violation_out = (user_mode && (mmr_hit || reg_bad)) || op_bad
                    || (req_in.mem_valid && prot_deny_in);
  end

endmodule : ppmc_access_guard

`default_nettype wire

/* design/ppmc_return_unit.sv */
/*
  Combinational return handling: which pending bit a return clears and where it resumes.
  Assumes the caller has already vetoed returns that violate privilege.
*/
`timescale 1ns/100ps
`default_nettype none

module ppmc_return_unit
  import ppmc_pkg::*;
(
  input  wire ppmc_pkg::ppmc_op_t  op_in,
  input  wire logic [15:0]         vec_in,
  input  wire ppmc_pkg::ppmc_ret_t ret_in,
  output logic [15:0]              clear_mask_out,
  output logic                     resume_out,
  output logic [31:0]              addr_out
);

  logic [4:0] lvl;

  always_comb
  begin
    lvl            = ppmc_active_level(vec_in);
    clear_mask_out = VEC_CLEAR;
    resume_out     = 1'b0;
    addr_out       = ADDR_CLEAR;
    case (op_in)
      OP_RET_INT:
      begin
        // Leaves the reset service or the innermost interrupt.
        if (lvl == 5'(BIT_RST) || (lvl >= 5'(BIT_INT_FIRST) && lvl < 5'(LVL_NONE)))
          clear_mask_out[lvl[3:0]] = 1'b1;
        resume_out = 1'b1;
        addr_out   = ret_in.int_ret;
      end
      OP_RET_EXC:
      begin
        clear_mask_out[BIT_EXC] = 1'b1;
        resume_out              = 1'b1;
        addr_out                = ret_in.exc_ret;
      end
      OP_RET_NMI:
      begin
        clear_mask_out[BIT_NMI] = 1'b1;
        resume_out              = 1'b1;
        addr_out                = ret_in.nmi_ret;
      end
      OP_RET_EMU:
      begin
        clear_mask_out[BIT_EMU] = 1'b1;
        resume_out              = 1'b1;
        addr_out                = ret_in.emu_ret;
      end
      default:
        resume_out = 1'b0;
    endcase
  end

endmodule : ppmc_return_unit

`default_nettype wire

/* dv/processor_privilege_mode_control_tb.sv */
/*
  Self-checking bench for the privilege mode control core, driving its ports directly.
  Assumes ppmc_pkg is compiled first and that each request is answered one cycle after it is taken.
*/
`timescale 1ns/100ps
`default_nettype none

module processor_privilege_mode_control_tb;
  import ppmc_pkg::*;

  logic        clk_in     = 1'b0;
  logic        rst_in     = 1'b1;
  logic        emu_reset  = 1'b0;
  logic        emu_enable = 1'b0;
  logic        emu_event  = 1'b0;
  logic        evt_req    = 1'b0;
  logic [3:0]  evt_level  = 4'h0;
  logic        ret_saved  = 1'b0;
  logic        prot_deny  = 1'b0;
  logic        ce         = 1'b1;
  ppmc_req_t   req        = '0;
  ppmc_ret_t   ret        = {32'h0000_1000, 32'h0000_2000, 32'h0000_3000, 32'h0000_4000};
  logic [15:0] vec;
  ppmc_mode_t  mode;
  logic        grant;
  logic        exc;
  logic        res_valid;
  logic [31:0] res_addr;
  logic        kernel_sp;
  logic        int_en;
  int          num_errors = 0;
  int          checked    = 0;
  ppmc_op_t    prot [7]   = '{OP_RET_INT, OP_RET_EXC, OP_RET_NMI, OP_INT_DISABLE,
                              OP_INT_ENABLE, OP_RAISE, OP_RET_EMU};

  always #12.5 clk_in = ~clk_in;

  ppmc_core u_ppmc_core (
    .CLK_IN                   (clk_in),
    .RST_IN                   (rst_in),
    .CE_IN                    (ce),
    .EMU_RESET_IN             (emu_reset),
    .EMU_ENABLE_IN            (emu_enable),
    .EMU_EVENT_IN             (emu_event),
    .EVT_REQ_IN               (evt_req),
    .EVT_LEVEL_IN             (evt_level),
    .INT_RET_SAVED_IN         (ret_saved),
    .PROT_DENY_IN             (prot_deny),
    .REQ_IN                   (req),
    .RET_IN                   (ret),
    .PENDING_EVENT_VECTOR_OUT (vec),
    .MODE_OUT                 (mode),
    .GRANT_OUT                (grant),
    .EXCEPTION_OUT            (exc),
    .RESUME_VALID_OUT         (res_valid),
    .RESUME_ADDR_OUT          (res_addr),
    .KERNEL_SP_OUT            (kernel_sp),
    .INT_ENABLE_OUT           (int_en)
  );

  function automatic ppmc_mode_t exp_mode(input logic [15:0] v);
    if (v[0])
      return PPMC_EMU;
    if (v != 16'h0000)
      return PPMC_SUPER;
    return PPMC_USER;
  endfunction : exp_mode

  function automatic ppmc_req_t mk_op(input ppmc_op_t op);
    ppmc_req_t r;
    r = '0;
    r.op = op;
    return r;
  endfunction : mk_op

  function automatic ppmc_req_t mk_reg(input ppmc_regclass_t cls);
    ppmc_req_t r;
    r = '0;
    r.reg_valid = 1'b1;
    r.reg_class = cls;
    return r;
  endfunction : mk_reg

  function automatic ppmc_req_t mk_mem(input logic [31:0] addr, input logic wr);
    ppmc_req_t r;
    r = '0;
    r.mem_valid = 1'b1;
    r.mem_write = wr;
    r.mem_addr  = addr;
    return r;
  endfunction : mk_mem

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // The answer pulses stand for one cycle only, so they are sampled just after the answering edge.
  task automatic do_req(input ppmc_req_t r, input logic exc_exp, input logic res_exp,
                        input logic [31:0] addr_exp);
    @(posedge clk_in);
    req <= r;
    @(posedge clk_in);
    req <= '0;
    #1;
    check(32'(exc), 32'(exc_exp));
    check(32'(grant), 32'(!exc_exp));
    check(32'(res_valid), 32'(res_exp));
    if (res_exp)
      check(res_addr, addr_exp);
  endtask : do_req

  task automatic expect_vec(input logic [15:0] v);
    @(posedge clk_in);
    #1;
    check(32'(vec), 32'(v));
    check(32'(mode), 32'(exp_mode(v)));
    check(32'(kernel_sp), 32'(v != 16'h0000));
  endtask : expect_vec

  task automatic raise_evt(input logic [3:0] lvl);
    @(posedge clk_in);
    evt_req   <= 1'b1;
    evt_level <= lvl;
    @(posedge clk_in);
    evt_req   <= 1'b0;
  endtask : raise_evt

  // A refused user request must land in exception service; the handler then returns to user.
  task automatic user_bad(input ppmc_req_t r);
    do_req(r, 1'b1, 1'b0, 32'h0000_0000);
    expect_vec(16'h0008);
    do_req(mk_op(OP_RET_EXC), 1'b0, 1'b1, 32'h0000_2000);
    expect_vec(16'h0000);
  endtask : user_bad

  task automatic reset_dut(input logic er, input logic [15:0] v);
    @(posedge clk_in);
    rst_in    <= 1'b1;
    emu_reset <= er;
    repeat (10) @(posedge clk_in);
    #1;
    check(32'(vec), 32'h0000_0000);
    @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check(32'(vec), 32'(v));
    check(32'(mode), 32'(exp_mode(v)));
  endtask : reset_dut

  initial
  begin
    repeat (5000) @(posedge clk_in);
    num_errors++;
    complete_run();
  end

  initial
  begin
    reset_dut(1'b0, 16'h0002);
    do_req(mk_op(OP_INT_ENABLE), 1'b0, 1'b0, 32'h0000_0000);
    check(32'(int_en), 32'h0000_0001);
    raise_evt(4'hF);
    expect_vec(16'h0002);
    do_req(mk_mem(MMR_BASE, 1'b0), 1'b0, 1'b0, 32'h0000_0000);
    do_req(mk_reg(RC_SYSTEM), 1'b0, 1'b0, 32'h0000_0000);
    do_req(mk_reg(RC_USER_STACK_ALIAS), 1'b0, 1'b0, 32'h0000_0000);
    do_req(mk_op(OP_RET_INT), 1'b0, 1'b1, 32'h0000_1000);
    expect_vec(16'h0000);
    // With the clock enable low all state is frozen, so an offered interrupt is lost.
    ce <= 1'b0;
    raise_evt(4'hF);
    expect_vec(16'h0000);
    ce <= 1'b1;
    foreach (prot[i])
      user_bad(mk_op(prot[i]));
    check(32'(int_en), 32'h0000_0001);
    for (int c = 0; c < 14; c++)
      if (c >= int'(RC_USER_STACK_ALIAS))
        user_bad(mk_reg(ppmc_regclass_t'(c)));
      else
        do_req(mk_reg(ppmc_regclass_t'(c)), 1'b0, 1'b0, 32'h0000_0000);
    user_bad(mk_mem(MMR_BASE, 1'b0));
    user_bad(mk_mem(32'hFFFF_FFFC, 1'b1));
    do_req(mk_mem(32'hFFBF_FFFC, 1'b1), 1'b0, 1'b0, 32'h0000_0000);
    prot_deny <= 1'b1;
    user_bad(mk_mem(32'h0000_0100, 1'b0));
    prot_deny <= 1'b0;
    raise_evt(4'hF);
    expect_vec(16'h8000);
    raise_evt(4'h2);
    expect_vec(16'h8004);
    do_req(mk_op(OP_RET_NMI), 1'b0, 1'b1, 32'h0000_3000);
    expect_vec(16'h8000);
    raise_evt(4'hC);
    expect_vec(16'h8000);
    ret_saved <= 1'b1;
    raise_evt(4'hC);
    ret_saved <= 1'b0;
    expect_vec(16'h9000);
    do_req(mk_op(OP_RET_INT), 1'b0, 1'b1, 32'h0000_1000);
    expect_vec(16'h8000);
    do_req(mk_op(OP_EMU_EXCEPTION), 1'b0, 1'b0, 32'h0000_0000);
    expect_vec(16'h8000);
    emu_enable <= 1'b1;
    do_req(mk_op(OP_EMU_EXCEPTION), 1'b0, 1'b0, 32'h0000_0000);
    expect_vec(16'h8001);
    do_req(mk_op(OP_RET_EMU), 1'b0, 1'b1, 32'h0000_4000);
    expect_vec(16'h8000);
    do_req(mk_op(OP_RET_INT), 1'b0, 1'b1, 32'h0000_1000);
    expect_vec(16'h0000);
    do_req(mk_op(OP_EMU_EXCEPTION), 1'b0, 1'b0, 32'h0000_0000);
    expect_vec(16'h0001);
    do_req(mk_op(OP_RET_EMU), 1'b0, 1'b1, 32'h0000_4000);
    expect_vec(16'h0000);
    // The pin passes a two-flop synchroniser, so a fixed six cycles covers its delay.
    @(posedge clk_in);
    emu_event <= 1'b1;
    repeat (6) @(posedge clk_in);
    emu_event <= 1'b0;
    expect_vec(16'h0001);
    reset_dut(1'b1, 16'h0003);
    complete_run();
  end

endmodule : processor_privilege_mode_control_tb

`default_nettype wire
